// ===== rtl/ssbm_pkg.sv
// Constants and carriers for the stepper standby and brake monitor
package ssbm_pkg;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int STARTUP_NS = 10000;
  localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  // Angle: 128 micro positions per electrical turn
  localparam int ANG_W = 7;
  localparam logic [6:0] ANG_INIT = 7'h10;
  localparam logic [6:0] RATIO_FULL = 7'h64;
  localparam logic [5:0] IDX_QUARTER = 6'h18;
  localparam logic [5:0] IDX_DIAG = 6'h10;
  localparam logic [5:0] IDX_TOP = 6'h20;
  // Resolution select codes
  localparam logic [2:0] RES_LOW_POWER_SELECT = 3'h0;
  localparam logic [2:0] RES_FULL = 3'h1;
  localparam logic [2:0] RES_HALF_A = 3'h2;
  localparam logic [2:0] RES_QUARTER = 3'h3;
  localparam logic [2:0] RES_HALF_B = 3'h4;
  localparam logic [2:0] RES_EIGHTH = 3'h5;
  localparam logic [2:0] RES_SIXTEENTH = 3'h6;
  localparam logic [2:0] RES_32ND = 3'h7;
  // Register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_MASK = 2'h1;
  localparam logic [1:0] REG_STATE = 2'h2;
  localparam int EV_W = 2;
  localparam int EV_ERR = 0;
  localparam int EV_HOME = 1;
  localparam logic [1:0] EV_RESET = 2'h0;
  // Current ratio table in percent
  localparam logic [6:0] RATIO_TBL [0:32] = '{
    7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1D, 7'h22,
    7'h26, 7'h2B, 7'h2F, 7'h34, 7'h38, 7'h3C, 7'h3F, 7'h43,
    7'h47, 7'h4A, 7'h4D, 7'h50, 7'h53, 7'h56, 7'h58, 7'h5A,
    7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64,
    7'h64};
  // Pins from the host and the analog side
  typedef struct packed {
    logic step;
    logic dir;
    logic brake;
    logic [2:0] res;
    logic rst;
    logic thermal_shutdown;
    logic overcurrent_shutdown;
    logic vm_ok;
    logic cc_off;
  } ssbm_pin_s;
  // Winding drive toward the power stage
  typedef struct packed {
    logic [6:0] a_mag;
    logic a_neg;
    logic [6:0] b_mag;
    logic b_neg;
    logic all_on;
    logic bias_en;
  } ssbm_drive_s;
  // Whole state of the core
  typedef struct packed {
    ssbm_pin_s s1;
    ssbm_pin_s s2;
    ssbm_pin_s s3;
    ssbm_pin_s flt;
    logic [6:0] angle;
    logic standby;
    logic err;
    logic [7:0] startup;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    ssbm_drive_s drv;
    logic home_oe;
    logic err_oe;
    logic irq;
  } ssbm_state_s;
endpackage

// ===== rtl/ssbm_core.sv
// Step sequencer with standby, error latch, brake and monitor flags
`timescale 1ns/1ps
module ssbm_core (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire ssbm_pkg::ssbm_pin_s pins_in,
  input wire logic [ssbm_pkg::ADDR_W-1:0] addr_in,
  input wire logic [ssbm_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [ssbm_pkg::DATA_W-1:0] rd_data_out,
  output ssbm_pkg::ssbm_drive_s drive_out,
  output logic initial_angle_flag_oe_out,
  output logic error_flag_oe_out,
  output logic irq_out
);

  // Registered state and its next value
  ssbm_pkg::ssbm_state_s q;
  ssbm_pkg::ssbm_state_s d;

  // Helpers shared by logic and checks
  logic step_rise;
  logic step_ok;
  logic at_home;
  logic [5:0] step_sz;
  logic [5:0] ia;
  logic [5:0] ib;
  logic [4:0] off;
  logic [1:0] quad;
  logic [1:0] ev;
  logic [1:0] clr;
  logic [10:0] agree;

  // Magnitude for one channel, with mode overrides
  function automatic logic [6:0] ratio_of(
    input logic [5:0] idx,
    input logic [2:0] res
  );
    logic [6:0] m;
    m = ssbm_pkg::RATIO_TBL[idx];
    // Full step drives any live phase at full
    if (res == ssbm_pkg::RES_FULL && idx != 6'h00) begin
      m = ssbm_pkg::RATIO_FULL;
    end
    // Half (a) diagonal at full
    if (res == ssbm_pkg::RES_HALF_A && idx == ssbm_pkg::IDX_DIAG) begin
      m = ssbm_pkg::RATIO_FULL;
    end
    // Quarter marked position at full
    if (res == ssbm_pkg::RES_QUARTER && idx == ssbm_pkg::IDX_QUARTER) begin
      m = ssbm_pkg::RATIO_FULL;
    end
    return m;
  endfunction

  // Next state
  always_comb begin
    d = q;
    // Three-stage pin synchronisers
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Accept a change once stages two and three agree
    agree = ~(q.s2 ^ q.s3);
    d.flt = (agree & q.s3) | (~agree & q.flt);
    // Step size per resolution
    unique case (q.flt.res)
      ssbm_pkg::RES_FULL: step_sz = 6'h20;
      ssbm_pkg::RES_HALF_A: step_sz = 6'h10;
      ssbm_pkg::RES_QUARTER: step_sz = 6'h08;
      ssbm_pkg::RES_HALF_B: step_sz = 6'h10;
      ssbm_pkg::RES_EIGHTH: step_sz = 6'h04;
      ssbm_pkg::RES_SIXTEENTH: step_sz = 6'h02;
      default: step_sz = 6'h01;
    endcase
    // Standby from all selects low
    d.standby = (q.flt.res == ssbm_pkg::RES_LOW_POWER_SELECT);
    // Startup window after leaving standby
    if (q.standby && !d.standby) begin
      d.startup = ssbm_pkg::STARTUP_CYC[7:0];
    end else if (q.startup != 8'h00) begin
      d.startup = q.startup - 8'h01;
    end
    // Only rising edges count, falling ones ignored
    step_rise = d.flt.step & ~q.flt.step;
    // Edges during standby or startup are dropped
    step_ok = step_rise && !q.standby && q.startup == 8'h00;
    // Angle reset wins over stepping
    if (q.flt.rst) begin
      d.angle = ssbm_pkg::ANG_INIT;
    end else if (step_ok) begin
      // Brake does not stop the angle
      if (q.flt.dir) begin
        d.angle = q.angle + {1'b0, step_sz};
      end else begin
        d.angle = q.angle - {1'b0, step_sz};
      end
    end
    // Error latch: standby or supply loss clears it
    if (d.standby || !q.flt.vm_ok) begin
      d.err = 1'b0;
    end else if (q.flt.thermal_shutdown || q.flt.overcurrent_shutdown) begin
      d.err = 1'b1;
    end
    // Table index per channel from quadrant and offset
    quad = q.angle[6:5];
    off = q.angle[4:0];
    if (quad[0]) begin
      ia = {1'b0, off};
      ib = ssbm_pkg::IDX_TOP - {1'b0, off};
    end else begin
      ia = ssbm_pkg::IDX_TOP - {1'b0, off};
      ib = {1'b0, off};
    end
    // Signs: plus side on means positive
    d.drv.a_neg = quad[1] ^ quad[0];
    d.drv.b_neg = quad[1];
    // Magnitudes from the table
    d.drv.a_mag = ratio_of(ia, q.flt.res);
    d.drv.b_mag = ratio_of(ib, q.flt.res);
    // Brake holds signed full current
    if (q.flt.brake) begin
      d.drv.a_mag = ssbm_pkg::RATIO_FULL;
      d.drv.b_mag = ssbm_pkg::RATIO_FULL;
    end
    // Brake without current control: all transistors on
    d.drv.all_on = q.flt.brake && q.flt.cc_off;
    d.drv.bias_en = !d.standby;
    // Output stage off in standby
    if (d.standby) begin
      d.drv.a_mag = 7'h00;
      d.drv.b_mag = 7'h00;
      d.drv.all_on = 1'b0;
    end
    // Monitor pull-down enables
    at_home = (q.angle == ssbm_pkg::ANG_INIT);
    d.home_oe = at_home;
    d.err_oe = d.err;
    // Events: error latched, initial angle reached
    ev = ssbm_pkg::EV_RESET;
    ev[ssbm_pkg::EV_ERR] = d.err && !q.err;
    ev[ssbm_pkg::EV_HOME] = at_home && !q.home_oe;
    // Write one to clear; a new event wins
    clr = 2'h0;
    if (wr_in && addr_in == ssbm_pkg::REG_STATUS) begin
      clr = wr_data_in[1:0];
    end
    d.status = (q.status & ~clr) | ev;
    // Mask write
    if (wr_in && addr_in == ssbm_pkg::REG_MASK) begin
      d.mask = wr_data_in[1:0];
    end
    d.irq = |(d.status & d.mask);
    // Read data lives one cycle only
    d.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        ssbm_pkg::REG_STATUS: d.rdata = {6'h00, q.status};
        ssbm_pkg::REG_MASK: d.rdata = {6'h00, q.mask};
        ssbm_pkg::REG_STATE: d.rdata = {q.err, q.angle};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.angle <= ssbm_pkg::ANG_INIT;
      q.standby <= 1'b1;
      q.home_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign rd_data_out = q.rdata;
  assign drive_out = q.drv;
  assign initial_angle_flag_oe_out = q.home_oe;
  assign error_flag_oe_out = q.err_oe;
  assign irq_out = q.irq;

  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  // 32nd-resolution step edge as seen by the sequencer
  sequence fine_step_s;
    step_ok && !q.flt.rst && q.flt.res == ssbm_pkg::RES_32ND;
  endsequence

  // Full-resolution step edge
  sequence full_step_s;
    step_ok && !q.flt.rst && q.flt.res == ssbm_pkg::RES_FULL;
  endsequence

  // Angle at home, then the flag one edge later
  sequence home_follow_s;
    q.angle == ssbm_pkg::ANG_INIT ##1 initial_angle_flag_oe_out;
  endsequence

  low_power_select_bias_a: assert property (
    q.flt.res == ssbm_pkg::RES_LOW_POWER_SELECT |=> !drive_out.bias_en)
    else $error("bias left on in standby");

  low_power_select_clear_a: assert property (
    q.flt.res == ssbm_pkg::RES_LOW_POWER_SELECT |=> !error_flag_oe_out)
    else $error("error not cleared by standby");

  err_hold_a: assert property (
    q.err && q.flt.res != ssbm_pkg::RES_LOW_POWER_SELECT && q.flt.vm_ok |=> q.err)
    else $error("error latch dropped");

  err_set_a: assert property (
    (q.flt.thermal_shutdown || q.flt.overcurrent_shutdown) && q.flt.res != ssbm_pkg::RES_LOW_POWER_SELECT
    && q.flt.vm_ok |=> error_flag_oe_out)
    else $error("error flag not pulled low");

  supply_clr_a: assert property (
    !q.flt.vm_ok |=> !error_flag_oe_out)
    else $error("error flag kept over supply loss");

  startup_a: assert property (
    q.startup != 8'h00 && !q.flt.rst |=> $stable(q.angle))
    else $error("angle moved during startup");

  cw_step_a: assert property (
    fine_step_s and q.flt.dir |=> q.angle == $past(q.angle) + 7'h01)
    else $error("clockwise step wrong");

  brake_step_a: assert property (
    fine_step_s and q.flt.brake and !q.flt.dir
    |=> q.angle == $past(q.angle) - 7'h01)
    else $error("angle frozen under brake");

  brake_full_a: assert property (
    q.flt.brake && q.flt.res != ssbm_pkg::RES_LOW_POWER_SELECT
    |=> drive_out.a_mag == 7'h64 && drive_out.b_mag == 7'h64)
    else $error("brake not at full current");

  all_on_a: assert property (
    q.flt.brake && q.flt.cc_off && q.flt.res != ssbm_pkg::RES_LOW_POWER_SELECT
    |=> drive_out.all_on)
    else $error("all outputs not on");

  half_a_a: assert property (
    q.angle[4:0] == 5'h10 && q.flt.res == ssbm_pkg::RES_HALF_A
    |=> drive_out.a_mag == 7'h64 && drive_out.b_mag == 7'h64)
    else $error("half a diagonal not full");

  quarter_a: assert property (
    q.angle[5:0] == 6'h18 && q.flt.res == ssbm_pkg::RES_QUARTER
    && !q.flt.brake
    |=> drive_out.a_mag == 7'h26 && drive_out.b_mag == 7'h64)
    else $error("quarter mark not full");

  table_a: assert property (
    q.angle == 7'h10 && q.flt.res == ssbm_pkg::RES_32ND
    && !q.flt.brake |=> drive_out.a_mag == 7'h47)
    else $error("diagonal ratio not 71");

  sign_a: assert property (
    q.angle == 7'h30 |=> drive_out.a_neg && !drive_out.b_neg)
    else $error("winding sign wrong");

  home_a: assert property (
    initial_angle_flag_oe_out == $past(at_home))
    else $error("angle flag mismatch");

  reset_a: assert property (
    q.flt.rst |=> home_follow_s)
    else $error("angle reset failed");

  full_step_a: assert property (
    full_step_s and q.flt.dir |=> q.angle == $past(q.angle) + 7'h20)
    else $error("full step size wrong");

  fall_hold_a: assert property (
    !step_rise && !q.flt.rst |=> $stable(q.angle))
    else $error("angle moved without rising edge");

  low_power_select_step_a: assert property (
    q.standby && !q.flt.rst |=> $stable(q.angle))
    else $error("angle moved in standby");

  low_power_select_off_a: assert property (
    q.flt.res == ssbm_pkg::RES_LOW_POWER_SELECT |=> drive_out.a_mag == 7'h00
    && drive_out.b_mag == 7'h00 && !drive_out.all_on)
    else $error("output stage on in standby");

  wake_load_a: assert property (
    $fell(q.standby) |-> q.startup == ssbm_pkg::STARTUP_CYC[7:0])
    else $error("startup window not loaded");

  err_event_a: assert property (
    $rose(q.err) |-> q.status[ssbm_pkg::EV_ERR])
    else $error("error event not recorded");

  irq_level_a: assert property (
    irq_out == (|(q.status & q.mask)))
    else $error("interrupt level wrong");

  rdata_idle_a: assert property (
    rd_in == 1'b0 |=> rd_data_out == 8'h00)
    else $error("read data outlived its cycle");

  half_b_a: assert property (
    q.angle == ssbm_pkg::ANG_INIT && q.flt.res == ssbm_pkg::RES_HALF_B
    && !q.flt.brake |=> drive_out.a_mag == 7'h47)
    else $error("half b diagonal not 71");

endmodule

// ===== verification/ssbm_host_model.sv
// Host controller model driving step, direction and mode pins
`timescale 1ns/1ps
module ssbm_host_model (
  input wire logic clock_in,
  output ssbm_pkg::ssbm_pin_s pins_out
);
  localparam int SETTLE = 8; // Sync, filter and output latency

  // Idle pins: no standby exit yet, supply good
  initial begin
    pins_out = '0;
    pins_out.dir = 1'h1;
    pins_out.vm_ok = 1'h1;
  end

  // Apply a whole pin setting after an edge, then let it settle
  task automatic put(input ssbm_pkg::ssbm_pin_s p);
    logic wake;
    wake = (pins_out.res == ssbm_pkg::RES_LOW_POWER_SELECT) &&
      (p.res != ssbm_pkg::RES_LOW_POWER_SELECT);
    @(posedge clock_in);
    pins_out <= p;
    repeat (SETTLE) @(posedge clock_in);
    // Quiet through startup after leaving standby
    if (wake) begin
      repeat (ssbm_pkg::STARTUP_CYC + SETTLE) @(posedge clock_in);
    end
    #1;
  endtask

  // Step pulses, each level held long enough to pass the filter
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock_in);
      pins_out.step <= 1'h1;
      repeat (6) @(posedge clock_in);
      pins_out.step <= 1'h0;
      repeat (6) @(posedge clock_in);
    end
    repeat (SETTLE) @(posedge clock_in);
    #1;
  endtask
endmodule

// ===== verification/stepper_standby_brake_monitor_tb_top.sv
// Self-checking bench for the standby, brake and monitor core
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module stepper_standby_brake_monitor_tb_top;
  logic clock_in; // Core clock
  logic rst_in; // Async reset
  ssbm_pkg::ssbm_pin_s pins; // Pins from the host model
  ssbm_pkg::ssbm_pin_s p; // Next pin setting
  logic [1:0] addr; // Register address
  logic [7:0] wdata; // Register write data
  logic wr; // Write strobe
  logic rd; // Read strobe
  logic [7:0] rdata; // Read data
  ssbm_pkg::ssbm_drive_s drv; // Winding drive
  logic home_oe; // Angle flag pull-down
  logic err_oe; // Error flag pull-down
  logic irq; // Interrupt level
  int err_count = 0; // Mismatches
  int samples_checked = 0; // Comparisons

  // 50 ns clock
  always #25 clock_in = ~clock_in;

  ssbm_host_model u_host (.clock_in(clock_in), .pins_out(pins));

  ssbm_core u_dut (
    .clock_in(clock_in), .rst_in(rst_in), .pins_in(pins),
    .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rdata), .drive_out(drv),
    .initial_angle_flag_oe_out(home_oe), .error_flag_oe_out(err_oe),
    .irq_out(irq)
  );

  // One-cycle write, settled afterwards
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock_in);
    wr <= 1'h0;
    #1;
  endtask

  // One-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock_in);
    rd <= 1'h0;
    #1;
    `CHK(rdata, e)
  endtask

  // Compare both channel magnitudes and signs
  task automatic chk_drv(input logic [6:0] am, input logic an,
                         input logic [6:0] bm, input logic bn);
    `CHK(drv.a_mag, am)
    `CHK(drv.a_neg, an)
    `CHK(drv.b_mag, bm)
    `CHK(drv.b_neg, bn)
  endtask

  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge clock_in);
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    clock_in = 1'h0;
    rst_in = 1'h1;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    p = '0;
    p.dir = 1'h1;
    p.vm_ok = 1'h1;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'h0;
    repeat (8) @(posedge clock_in);
    #1;
    `CHK(home_oe, 1'h1)
    `CHK(err_oe, 1'h0)
    `CHK(drv.bias_en, 1'h0)
    rd_reg(2'h2, 8'h10);
    u_host.step(1);
    rd_reg(2'h2, 8'h10);
    $display("test standby done");
    p.res = ssbm_pkg::RES_FULL;
    u_host.put(p);
    `CHK(drv.bias_en, 1'h1)
    chk_drv(7'h64, 1'h0, 7'h64, 1'h0);
    u_host.step(1);
    rd_reg(2'h2, 8'h30);
    `CHK(home_oe, 1'h0)
    chk_drv(7'h64, 1'h1, 7'h64, 1'h0);
    p.res = ssbm_pkg::RES_HALF_A;
    u_host.put(p);
    u_host.step(1);
    chk_drv(7'h64, 1'h1, 7'h00, 1'h1);
    u_host.step(1);
    chk_drv(7'h64, 1'h1, 7'h64, 1'h1);
    p.res = ssbm_pkg::RES_QUARTER;
    u_host.put(p);
    u_host.step(1);
    chk_drv(7'h26, 1'h1, 7'h64, 1'h1);
    p.res = ssbm_pkg::RES_32ND;
    u_host.put(p);
    u_host.step(1);
    chk_drv(7'h22, 1'h1, 7'h5E, 1'h1);
    p.dir = 1'h0;
    u_host.put(p);
    u_host.step(1);
    rd_reg(2'h2, 8'h58);
    $display("test resolution done");
    p.brake = 1'h1;
    u_host.put(p);
    chk_drv(7'h64, 1'h1, 7'h64, 1'h1);
    u_host.step(1);
    rd_reg(2'h2, 8'h57);
    p.cc_off = 1'h1;
    u_host.put(p);
    `CHK(drv.all_on, 1'h1)
    p.brake = 1'h0;
    p.cc_off = 1'h0;
    u_host.put(p);
    `CHK(drv.all_on, 1'h0)
    chk_drv(7'h2B, 1'h1, 7'h5A, 1'h1);
    $display("test brake done");
    wr_reg(2'h0, 8'h03);
    wr_reg(2'h1, 8'hFF);
    rd_reg(2'h1, 8'h03);
    p.rst = 1'h1;
    u_host.put(p);
    rd_reg(2'h2, 8'h10);
    `CHK(home_oe, 1'h1)
    rd_reg(2'h0, 8'h02);
    `CHK(irq, 1'h1)
    p.rst = 1'h0;
    u_host.put(p);
    wr_reg(2'h1, 8'h01);
    `CHK(irq, 1'h0)
    $display("test home done");
    p.thermal_shutdown = 1'h1;
    u_host.put(p);
    p.thermal_shutdown = 1'h0;
    u_host.put(p);
    `CHK(err_oe, 1'h1)
    `CHK(irq, 1'h1)
    rd_reg(2'h2, 8'h90);
    wr_reg(2'h0, 8'h01);
    `CHK(irq, 1'h0)
    `CHK(err_oe, 1'h1)
    p.vm_ok = 1'h0;
    u_host.put(p);
    p.vm_ok = 1'h1;
    u_host.put(p);
    `CHK(err_oe, 1'h0)
    p.overcurrent_shutdown = 1'h1;
    u_host.put(p);
    p.overcurrent_shutdown = 1'h0;
    u_host.put(p);
    `CHK(err_oe, 1'h1)
    p.res = ssbm_pkg::RES_LOW_POWER_SELECT;
    u_host.put(p);
    `CHK(err_oe, 1'h0)
    `CHK(drv.bias_en, 1'h0)
    `CHK(drv.a_mag, 7'h00)
    p.res = ssbm_pkg::RES_FULL;
    u_host.put(p);
    `CHK(err_oe, 1'h0)
    rd_reg(2'h2, 8'h10);
    $display("test errors done");
    p.res = ssbm_pkg::RES_HALF_B;
    u_host.put(p);
    u_host.step(1);
    rd_reg(2'h2, 8'h00);
    chk_drv(7'h64, 1'h0, 7'h00, 1'h0);
    p.dir = 1'h1;
    u_host.put(p);
    u_host.step(1);
    chk_drv(7'h47, 1'h0, 7'h47, 1'h0);
    p.res = ssbm_pkg::RES_32ND;
    u_host.put(p);
    chk_drv(7'h47, 1'h0, 7'h47, 1'h0);
    p.res = ssbm_pkg::RES_EIGHTH;
    u_host.put(p);
    u_host.step(1);
    chk_drv(7'h38, 1'h0, 7'h53, 1'h0);
    p.res = ssbm_pkg::RES_SIXTEENTH;
    u_host.put(p);
    u_host.step(1);
    rd_reg(2'h2, 8'h16);
    chk_drv(7'h2F, 1'h0, 7'h58, 1'h0);
    $display("test fine resolutions done");
    rd_reg(2'h3, 8'h00);
    wr_reg(2'h2, 8'hFF);
    rd_reg(2'h2, 8'h16);
    @(posedge clock_in);
    #1;
    `CHK(rdata, 8'h00)
    $display("test registers done");
    results();
  end
endmodule
